// ==== verilog/tpo_top.sv ====
`timescale 1ns/1ps
// Behaviour
// - outputs form four 4-bit groups that run independently.
// - sixteen output bits, each enabled for pattern output on its own.
// - each group picks its trigger from four timer channel matches.
// - non-overlap mode puts a guard margin between pulse edges.
// - a selected trigger match also raises a dma request.
// - pins 0-3 are group 0, 4-7 group 1, 8-11 group 2, 12-15 group 3.
// - port data bits used for pattern output ignore writes, stay readable.
// - lower next data sits at ffa5 if groups 0/1 share a trigger, else
// - upper next data sits at ffa4 if groups 2/3 share a trigger, else
// - reset gives mode f0, control ff, all other registers 00.
// - port a data holds what groups 0 and 1 currently drive.
module tpo_top
  import tpo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [N_CHAN-1:0] cmp_a,
  input wire logic [N_CHAN-1:0] cmp_b,
  output logic [N_CHAN-1:0] dma_req,
  output logic [OUT_W-1:0] pattern_out_pin,
  output logic [OUT_W-1:0] pattern_oe_n
);

  // ----------------------------------------------------------------
  // reset and state
  // ----------------------------------------------------------------
  logic rst_n;
  tpo_state_t s_q;
  tpo_state_t s_d;
  logic [OUT_W-1:0] grp_nxt;
  logic [N_GRP-1:0] grp_fire;
  logic [OUT_W-1:0] nd16;
  logic [OUT_W-1:0] en16;
  logic [OUT_W-1:0] cur16;
  logic same_lo;
  logic same_up;

  tpo_rst_sync u_rst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .rst_n(rst_n)
  );

  assign nd16 = {s_q.nd_up, s_q.nd_lo};
  assign en16 = {s_q.nde_up, s_q.nde_lo};
  assign cur16 = {s_q.dat_b, s_q.dat_a};
  assign same_lo = (s_q.ctrl[1:0] == s_q.ctrl[3:2]);
  assign same_up = (s_q.ctrl[5:4] == s_q.ctrl[7:6]);

  // ----------------------------------------------------------------
  // output groups
  // ----------------------------------------------------------------
  tpo_grp_if gi [N_GRP] ();

  for (genvar g = 0; g < N_GRP; g++)
  begin : g_grp
    assign gi[g].sel = s_q.ctrl[CTRL_SEL_LSB + SEL_W*g +: SEL_W];
    assign gi[g].nov = s_q.mode[MODE_NOV_LSB + g];
    assign gi[g].cmp_a = cmp_a;
    assign gi[g].cmp_b = cmp_b;
    assign gi[g].nd = nd16[GRP_W*g +: GRP_W];
    assign gi[g].en = en16[GRP_W*g +: GRP_W];
    assign gi[g].cur = cur16[GRP_W*g +: GRP_W];
    assign grp_nxt[GRP_W*g +: GRP_W] = gi[g].nxt;
    assign grp_fire[g] = gi[g].fire;
    tpo_group u_grp (
      .gif(gi[g].grp)
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = REG_ZERO;
    s_d.dma_req = '0;
    // group results first; a cpu write may only touch unused bits
    s_d.dat_a = grp_nxt[7:0];
    s_d.dat_b = grp_nxt[15:8];
    for (int g = 0; g < N_GRP; g++)
    begin
      if (grp_fire[g])
        s_d.dma_req[s_q.ctrl[SEL_W*g +: SEL_W]] = 1'b1;
    end
    if (wr)
    begin
      case (addr)
        ADR_MODE: s_d.mode = {MODE_RSVD, wdata[3:0]};
        ADR_CTRL: s_d.ctrl = wdata;
        ADR_NDE_UP: s_d.nde_up = wdata;
        ADR_NDE_LO: s_d.nde_lo = wdata;
        ADR_ND_LO:
        begin
          if (same_lo)
            s_d.nd_lo = wdata;
          else
            s_d.nd_lo[7:4] = wdata[7:4];
        end
        ADR_ND_LO_G0:
        begin
          if (!same_lo)
            s_d.nd_lo[3:0] = wdata[3:0];
        end
        ADR_ND_UP:
        begin
          if (same_up)
            s_d.nd_up = wdata;
          else
            s_d.nd_up[7:4] = wdata[7:4];
        end
        ADR_ND_UP_G2:
        begin
          if (!same_up)
            s_d.nd_up[3:0] = wdata[3:0];
        end
        ADR_DIR_A:
        begin
          s_d.dir_a = wdata;
          s_d.oe_n[7:0] = ~wdata;
        end
        ADR_DIR_B:
        begin
          s_d.dir_b = wdata;
          s_d.oe_n[15:8] = ~wdata;
        end
        ADR_DAT_A:
          s_d.dat_a = (grp_nxt[7:0] & s_q.nde_lo) | (wdata & ~s_q.nde_lo);
        ADR_DAT_B:
          s_d.dat_b = (grp_nxt[15:8] & s_q.nde_up) | (wdata & ~s_q.nde_up);
        default: ;
      endcase
    end
    if (rd)
    begin
      case (addr)
        ADR_MODE: s_d.rdata = s_q.mode;
        ADR_CTRL: s_d.rdata = s_q.ctrl;
        ADR_NDE_UP: s_d.rdata = s_q.nde_up;
        ADR_NDE_LO: s_d.rdata = s_q.nde_lo;
        ADR_ND_LO:
          s_d.rdata = same_lo ? s_q.nd_lo : {s_q.nd_lo[7:4], 4'h0};
        ADR_ND_LO_G0:
          s_d.rdata = same_lo ? REG_ZERO : {4'h0, s_q.nd_lo[3:0]};
        ADR_ND_UP:
          s_d.rdata = same_up ? s_q.nd_up : {s_q.nd_up[7:4], 4'h0};
        ADR_ND_UP_G2:
          s_d.rdata = same_up ? REG_ZERO : {4'h0, s_q.nd_up[3:0]};
        ADR_DAT_A: s_d.rdata = s_q.dat_a;
        ADR_DAT_B: s_d.rdata = s_q.dat_b;
        // direction registers are write-only and read as zero
        default: s_d.rdata = REG_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.mode <= MODE_RST;
      s_q.ctrl <= CTRL_RST;
      s_q.nde_up <= REG_ZERO;
      s_q.nde_lo <= REG_ZERO;
      s_q.nd_up <= REG_ZERO;
      s_q.nd_lo <= REG_ZERO;
      s_q.dir_a <= REG_ZERO;
      s_q.dir_b <= REG_ZERO;
      s_q.dat_a <= REG_ZERO;
      s_q.dat_b <= REG_ZERO;
      s_q.oe_n <= '1;
      s_q.rdata <= REG_ZERO;
      s_q.dma_req <= '0;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = s_q.rdata;
  assign dma_req = s_q.dma_req;
  assign pattern_out_pin = {s_q.dat_b, s_q.dat_a};
  // pins only leave high impedance once software sets direction
  assign pattern_oe_n = s_q.oe_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_mode_rsvd_ones: assert property (
    s_q.mode[7:4] == MODE_RSVD
    && (!$rose(rst_n) || (s_q.ctrl == CTRL_RST && s_q.mode == MODE_RST)))
    else $error("mode reserved bits or control reset value wrong");

  a_port_lock_bits: assert property (
    (wr && addr == ADR_DAT_A && cmp_a == '0 && cmp_b == '0)
    |=> ((s_q.dat_a ^ $past(s_q.dat_a)) & $past(s_q.nde_lo)) == 8'h00)
    else $error("enabled port bit changed by cpu write");

  a_group0_load: assert property (
    (cmp_a[s_q.ctrl[1:0]] && !s_q.mode[0] && !wr)
    |=> s_q.dat_a[3:0] ==
        (($past(s_q.nd_lo[3:0]) & $past(s_q.nde_lo[3:0]))
        | ($past(s_q.dat_a[3:0]) & ~$past(s_q.nde_lo[3:0]))))
    else $error("group 0 did not load next data on its trigger");

  a_nov_no_rise: assert property (
    (s_q.mode[0] && cmp_b == '0 && !wr)
    |=> (s_q.dat_a[3:0] & ~$past(s_q.dat_a[3:0])) == 4'h0)
    else $error("non-overlap group 0 rose without match b");

  a_dma_on_match: assert property (
    cmp_a[s_q.ctrl[1:0]] |=> dma_req[$past(s_q.ctrl[1:0])])
    else $error("selected match did not raise dma request");

  a_ndr_lo_shared: assert property (
    (wr && addr == ADR_ND_LO && same_lo) |=> s_q.nd_lo == $past(wdata))
    else $error("shared lower next data write lost");

  a_ndr_up_split: assert property (
    (wr && addr == ADR_ND_UP_G2 && !same_up)
    |=> s_q.nd_up[3:0] == $past(wdata[3:0])
        && s_q.nd_up[7:4] == $past(s_q.nd_up[7:4]))
    else $error("group 2 next data write wrong");

  a_port_a_read: assert property (
    (rd && addr == ADR_DAT_A) |=> rdata == $past(s_q.dat_a) ##1
    rdata == 8'h00 || $past(rd))
    else $error("port a read data wrong");

  a_dir_drives_oe: assert property (
    (wr && addr == ADR_DIR_A) |=> pattern_oe_n[7:0] == ~$past(wdata))
    else $error("output enable does not follow direction write");

endmodule // tpo_top

// ==== verilog/tpo_pkg.sv ====
package tpo_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int N_GRP = 4;
  localparam int GRP_W = 4;
  localparam int N_CHAN = 4;
  localparam int SEL_W = 2;
  localparam int OUT_W = 16;

  // ----------------------------------------------------------------
  // register byte addresses (lower 16 bits)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADR_MODE = 16'hffa0;
  localparam logic [15:0] ADR_CTRL = 16'hffa1;
  localparam logic [15:0] ADR_NDE_UP = 16'hffa2;
  localparam logic [15:0] ADR_NDE_LO = 16'hffa3;
  localparam logic [15:0] ADR_ND_UP = 16'hffa4;
  localparam logic [15:0] ADR_ND_LO = 16'hffa5;
  localparam logic [15:0] ADR_ND_UP_G2 = 16'hffa6;
  localparam logic [15:0] ADR_ND_LO_G0 = 16'hffa7;
  localparam logic [15:0] ADR_DIR_A = 16'hffd1;
  localparam logic [15:0] ADR_DAT_A = 16'hffd3;
  localparam logic [15:0] ADR_DIR_B = 16'hffd4;
  localparam logic [15:0] ADR_DAT_B = 16'hffd6;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'hf0;
  localparam logic [7:0] CTRL_RST = 8'hff;
  localparam logic [7:0] REG_ZERO = 8'h00;
  localparam logic [3:0] MODE_RSVD = 4'hf;
  localparam int MODE_NOV_LSB = 0;
  localparam int CTRL_SEL_LSB = 0;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] nde_up;
    logic [7:0] nde_lo;
    logic [7:0] nd_up;
    logic [7:0] nd_lo;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dat_a;
    logic [7:0] dat_b;
    logic [15:0] oe_n;
    logic [7:0] rdata;
    logic [3:0] dma_req;
  } tpo_state_t;

endpackage

// ==== verilog/tpo_grp_if.sv ====
`timescale 1ns/1ps
interface tpo_grp_if;
  import tpo_pkg::*;
  logic [SEL_W-1:0] sel;
  logic nov;
  logic [N_CHAN-1:0] cmp_a;
  logic [N_CHAN-1:0] cmp_b;
  logic [GRP_W-1:0] nd;
  logic [GRP_W-1:0] en;
  logic [GRP_W-1:0] cur;
  logic [GRP_W-1:0] nxt;
  logic fire;
  modport grp (input sel, nov, cmp_a, cmp_b, nd, en, cur,
               output nxt, fire);
  modport ctl (output sel, nov, cmp_a, cmp_b, nd, en, cur,
               input nxt, fire);
endinterface

// ==== verilog/tpo_rst_sync.sv ====
`timescale 1ns/1ps
module tpo_rst_sync
  import tpo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  output logic rst_n
);

  typedef struct packed {
    logic [1:0] s;
  } tpo_rsync_t;

  tpo_rsync_t s_q;
  tpo_rsync_t s_d;

  // stage 0 feeds only stage 1
  always_comb
  begin
    s_d.s = {s_q.s[0], 1'b1};
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rst_n = s_q.s[1];

endmodule // tpo_rst_sync

// ==== verilog/tpo_group.sv ====
`timescale 1ns/1ps
module tpo_group
  import tpo_pkg::*;
(
  tpo_grp_if.grp gif
);

  logic hit_a;
  logic hit_b;
  logic [GRP_W-1:0] v;

  // ----------------------------------------------------------------
  // one 4-bit output group
  // ----------------------------------------------------------------
  always_comb
  begin
    hit_a = gif.cmp_a[gif.sel];
    hit_b = gif.cmp_b[gif.sel];
    v = gif.cur;
    if (!gif.nov)
    begin
      if (hit_a)
        v = (gif.cur & ~gif.en) | (gif.nd & gif.en);
    end
    else
    begin
      // falling bits go on match a, rising bits wait for match b,
      // so the a-to-b distance is the guard margin
      if (hit_a)
        v = v & ~(gif.en & ~gif.nd);
      if (hit_b)
        v = v | (gif.en & gif.nd);
    end
    gif.nxt = v;
    gif.fire = hit_a;
  end

endmodule // tpo_group

// ==== bench/tpo_timer_model.sv ====
`timescale 1ns/1ps
module tpo_timer_model
  import tpo_pkg::*;
(
  input wire logic clk_sys,
  output logic [N_CHAN-1:0] cmp_a,
  output logic [N_CHAN-1:0] cmp_b,
  input wire logic [N_CHAN-1:0] dma_req
);
  int dma_seen;

  initial
  begin
    cmp_a = '0;
    cmp_b = '0;
    dma_seen = 0;
  end

  // matches are one-cycle pulses; idle lines rest low like the real timer
  task automatic match(input logic [N_CHAN-1:0] a,
                       input logic [N_CHAN-1:0] b);
    @(posedge clk_sys);
    cmp_a <= a;
    cmp_b <= b;
    @(posedge clk_sys);
    cmp_a <= '0;
    cmp_b <= '0;
  endtask

  // the dma side only counts requests, it never stalls the block
  always @(posedge clk_sys)
    dma_seen <= dma_seen + $countones(dma_req);
endmodule // tpo_timer_model

// ==== bench/test_tpo_top.sv ====
`timescale 1ns/1ps
module test_tpo_top
  import tpo_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b1;
  logic [15:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [N_CHAN-1:0] cmp_a;
  logic [N_CHAN-1:0] cmp_b;
  logic [N_CHAN-1:0] dma_req;
  logic [OUT_W-1:0] pattern_out_pin;
  logic [OUT_W-1:0] pattern_oe_n;
  logic [7:0] v;
  int failures = 0;
  int checks_done = 0;
  int pins, en, nd, nov;
  logic [15:0] radr [12] = '{ADR_MODE, ADR_CTRL, ADR_NDE_UP, ADR_NDE_LO,
    ADR_ND_UP, ADR_ND_LO, ADR_ND_LO_G0, ADR_DIR_A, ADR_DAT_A, ADR_DIR_B,
    ADR_DAT_B, 16'hffa8};
  logic [7:0] rrst [12] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #12.5 clk_sys = ~clk_sys;

  tpo_top u_tpo_top (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmp_a(cmp_a),
    .cmp_b(cmp_b), .dma_req(dma_req), .pattern_out_pin(pattern_out_pin),
    .pattern_oe_n(pattern_oe_n));

  tpo_timer_model u_tpo_timer_model (.clk_sys(clk_sys), .cmp_a(cmp_a),
    .cmp_b(cmp_b), .dma_req(dma_req));

  // ----------------------------------------------------------------
  // bus and checking tasks
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // model of one group taking its trigger, b selects match b
  task automatic fire(input int g, input int b);
    int m;
    m = en & ('hf << (4 * g));
    if (nov[g] == 0 && b == 0) pins = (pins & ~m) | (nd & m);
    else if (nov[g] && b == 1) pins = pins | (nd & m);
    else if (nov[g]) pins = pins & ~(~nd & m);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    // a real falling edge, so the reset flops clear before the first clock
    nrst <= 1'b0;
    void'($urandom(32'h2fe2));
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    nov = 0;
    for (int i = 0; i < 12; i++)
    begin
      rd_reg(radr[i], v);
      check(16'(v), 16'(rrst[i]));
    end
    wr_reg(ADR_DIR_A, 8'hff);
    wr_reg(ADR_DIR_B, 8'hff);
    @(posedge clk_sys);
    #1 check(pattern_oe_n, 16'h0000);
    // each group on its own channel, so next data splits per nibble
    wr_reg(ADR_CTRL, 8'he4);
    repeat (3)
    begin
      wr_reg(ADR_NDE_LO, 8'h00);
      wr_reg(ADR_NDE_UP, 8'h00);
      pins = $urandom & 'hffff;
      wr_reg(ADR_DAT_A, 8'(pins));
      wr_reg(ADR_DAT_B, 8'(pins >> 8));
      en = $urandom & 'hffff;
      nd = $urandom & 'hffff;
      wr_reg(ADR_NDE_LO, 8'(en));
      wr_reg(ADR_NDE_UP, 8'(en >> 8));
      wr_reg(ADR_ND_LO_G0, {4'h0, 4'(nd)});
      wr_reg(ADR_ND_LO, {4'(nd >> 4), 4'h0});
      wr_reg(ADR_ND_UP_G2, {4'h0, 4'(nd >> 8)});
      wr_reg(ADR_ND_UP, {4'(nd >> 12), 4'h0});
      rd_reg(ADR_ND_LO_G0, v);
      check(16'(v), 16'(nd & 'hf));
      rd_reg(ADR_ND_UP, v);
      check(16'(v), 16'(nd >> 8 & 'hf0));
      for (int g = 0; g < 4; g++)
      begin
        u_tpo_timer_model.match(4'(1 << g), 4'h0);
        #1;
        fire(g, 0);
        check(pattern_out_pin, 16'(pins));
        check(16'(dma_req), 16'(1 << g));
      end
      v = 8'($urandom);
      wr_reg(ADR_DAT_A, v);
      // enabled bits and port b keep their value, the rest take the write
      pins = (pins & (en | 'hff00)) | (v & ~en & 'hff);
      rd_reg(ADR_DAT_A, v);
      check(16'(v), 16'(pins & 'hff));
      check(pattern_out_pin, 16'(pins));
    end
    // shared trigger on channel 0, first plain then non-overlap
    wr_reg(ADR_CTRL, 8'h00);
    wr_reg(ADR_NDE_LO, 8'hff);
    wr_reg(ADR_NDE_UP, 8'hff);
    en = 'hffff;
    for (int m = 0; m < 2; m++)
    begin
      nov = m ? 'hf : 0;
      wr_reg(ADR_MODE, 8'(nov));
      rd_reg(ADR_MODE, v);
      check(16'(v), 16'(nov | 'hf0));
      nd = $urandom & 'hffff;
      wr_reg(ADR_ND_LO, 8'(nd));
      wr_reg(ADR_ND_UP, 8'(nd >> 8));
      rd_reg(ADR_ND_LO_G0, v);
      check(16'(v), 16'h0000);
      for (int b = 0; b < 2; b++)
      begin
        u_tpo_timer_model.match(4'(1 - b), 4'(b));
        #1;
        for (int g = 0; g < 4; g++)
          fire(g, b);
        check(pattern_out_pin, 16'(pins));
        check(16'(dma_req), 16'(1 - b));
      end
    end
    // twelve split-trigger matches plus one match a per shared round
    check(16'(u_tpo_timer_model.dma_seen), 16'h000e);
    conclude();
  end

  // a hang is cut short at 6000 cycles, well past the couple of hundred cycles the tests need
  initial
  begin
    #(25 * 6000);
    failures++;
    conclude();
  end
endmodule // test_tpo_top
